// ===== hdl/alarm_relay_pkg.sv
// holds constants and types of the insulation alarm relay control
// assumes a single 20 MHz clock and no register bus
package alarm_relay_pkg;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_HZ        = 20_000_000;
	localparam int CLK_PERIOD_NS = 50;
	localparam int SECOND_S      = 1;
	localparam int SECOND_CYCLES = SECOND_S * CLK_HZ;
	localparam int SELFTEST_S    = 3;
	localparam int TICK_W        = 25;
	localparam int DELAY_W       = 13;

	localparam logic [1:0]         TEST_LOAD  = 2'(SELFTEST_S);
	localparam logic [1:0]         TEST_IDLE  = 2'h0;
	localparam logic [DELAY_W-1:0] DELAY_ZERO = 13'h0000;
	localparam logic [TICK_W-1:0]  TICK_ZERO  = 25'h000_0000;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		AL_NORMAL = 2'b00,
		AL_DELAY  = 2'b01,
		AL_ALARM  = 2'b10
	} alarm_t;

	typedef enum logic [2:0] {
		SCR_MONITOR  = 3'b000,
		SCR_INHIBIT  = 3'b001,
		SCR_MENU     = 3'b010,
		SCR_SETTINGS = 3'b011,
		SCR_SELFTEST = 3'b100
	} screen_t;

	typedef struct packed {
		logic               inhibitEnable;
		logic               inhibitTypeExt;
		logic               inhibitFeedback;
		logic               alarmRelaySilencing;
		logic               testWithRelays;
		logic [DELAY_W-1:0] alarmDelaySec;
	} config_t;

	typedef struct packed {
		logic ackPress;
		logic menuPress;
		logic arrowPress;
		logic testPress;
		logic escPress;
	} keys_t;

	typedef struct packed {
		logic prevRelay;
		logic insRelay;
		logic prevLed;
		logic alarmLed;
		logic relayConnect;
	} relays_t;

	localparam relays_t RELAYS_RST = 5'b0_0001;

	typedef struct packed {
		logic [TICK_W-1:0]  tickCnt;
		logic [DELAY_W-1:0] delayCnt;
		alarm_t             alarm;
		screen_t            screen;
		logic               silenced;
		logic               acked;
		logic               inhibPrev;
		logic [1:0]         testSec;
		logic               testManual;
		logic               transient;
		relays_t            out;
	} state_t;

endpackage : alarm_relay_pkg

// ===== hdl/insulation_alarm_relay_control.sv
// holds the alarm relay, indicator, screen and inhibition control
// assumes inputs synchronous to core_clk, comparator levels from the
// measurement path and debounced one-cycle button pulses
//
// Summary of operation
// - inhibition screen replaces status screens
// - internal style: self-test on re-enable
// - external style: straight to monitor screen
// - feedback on: insulation relay while inhibited
// - silencing on: acknowledge releases both relays
// - silencing off: relays held until recovery
// - preventive threshold switches relay and indicator
// - alarm after delay, relay and indicator
// - fault corrected clears indicator, normal status
// - manual self-test toggles relays three seconds
// - internal style isolates relay during inhibition
// - external style keeps relay connected
// - inhibition screen buttons: menu, settings, test
// - unacknowledged recovered alarm flagged transient
`timescale 1ns/100ps
module insulation_alarm_relay_control
	import alarm_relay_pkg::*;
#(
	parameter int SEC_TICKS = SECOND_CYCLES
) (
	input  logic    core_clk,
	input  logic    rst_b,
	input  config_t cfg,
	input  keys_t   keys,
	input  logic    injInhibit,
	input  logic    prevBelow,
	input  logic    insFault,
	output relays_t relays,
	output screen_t screen,
	output logic    selfTestActive,
	output logic    transientFault
);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	state_t s_q;
	state_t s_d;
	logic   inhibit;
	logic   tickPulse;
	logic   testToggle;
	logic   testStart;

	localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(SEC_TICKS - 1);

	assign inhibit = cfg.inhibitEnable & injInhibit;

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		s_d           = s_q;
		s_d.transient = 1'b0;
		tickPulse     = (s_q.tickCnt == TICK_LAST);
		s_d.tickCnt   = tickPulse ? TICK_ZERO : s_q.tickCnt + 1'b1;
		testStart     = 1'b0;
		s_d.inhibPrev = inhibit;

		// alarm sequence
		if (inhibit) begin
			s_d.alarm    = AL_NORMAL;
			s_d.silenced = 1'b0;
			s_d.acked    = 1'b0;
		end else begin
			unique case (s_q.alarm)
				AL_NORMAL: begin
					s_d.acked    = 1'b0;
					s_d.delayCnt = DELAY_ZERO;
					if (insFault) begin
						if (cfg.alarmDelaySec == DELAY_ZERO) begin
							s_d.alarm = AL_ALARM;
						end else begin
							s_d.alarm = AL_DELAY;
						end
					end
				end
				AL_DELAY: begin
					if (!insFault) begin
						s_d.alarm = AL_NORMAL;
					end else if (tickPulse) begin
						if (s_q.delayCnt + 1'b1 >= cfg.alarmDelaySec) begin
							s_d.alarm = AL_ALARM;
						end else begin
							s_d.delayCnt = s_q.delayCnt + 1'b1;
						end
					end
				end
				AL_ALARM: begin
					if (keys.ackPress) begin
						s_d.acked = 1'b1;
						if (cfg.alarmRelaySilencing) begin
							s_d.silenced = 1'b1;
						end
					end
					if (!insFault) begin
						s_d.alarm     = AL_NORMAL;
						s_d.transient = ~s_q.acked & ~keys.ackPress;
					end
				end
				default: s_d.alarm = AL_NORMAL;
			endcase
			if (!insFault && !prevBelow) begin
				s_d.silenced = 1'b0;
			end
		end

		// self-test timer
		if (s_q.testSec != TEST_IDLE && tickPulse) begin
			s_d.testSec = s_q.testSec - 1'b1;
		end

		// screens
		unique case (s_q.screen)
			SCR_MONITOR: begin
				if (inhibit) begin
					s_d.screen = SCR_INHIBIT;
				end else if (keys.testPress) begin
					testStart      = 1'b1;
					s_d.testManual = 1'b1;
				end else if (keys.menuPress) begin
					s_d.screen = SCR_MENU;
				end else if (keys.arrowPress) begin
					s_d.screen = SCR_SETTINGS;
				end
			end
			SCR_INHIBIT: begin
				if (!inhibit) begin
					if (cfg.inhibitTypeExt) begin
						s_d.screen = SCR_MONITOR;
					end else begin
						testStart      = 1'b1;
						s_d.testManual = 1'b0;
					end
				end else if (keys.menuPress) begin
					s_d.screen = SCR_MENU;
				end else if (keys.arrowPress) begin
					s_d.screen = SCR_SETTINGS;
				end else if (keys.testPress) begin
					testStart      = 1'b1;
					s_d.testManual = 1'b1;
				end
			end
			SCR_MENU, SCR_SETTINGS: begin
				if (keys.escPress) begin
					s_d.screen = inhibit ? SCR_INHIBIT : SCR_MONITOR;
				end
			end
			SCR_SELFTEST: begin
				if (s_q.testSec == TEST_IDLE) begin
					s_d.screen = inhibit ? SCR_INHIBIT : SCR_MONITOR;
				end
			end
			default: s_d.screen = SCR_MONITOR;
		endcase
		if (testStart) begin
			s_d.screen  = SCR_SELFTEST;
			s_d.testSec = TEST_LOAD;
			s_d.tickCnt = TICK_ZERO;
		end

		// relay outputs
		testToggle = (s_d.testSec != TEST_IDLE) & s_d.testManual
			& cfg.testWithRelays;
		s_d.out.prevRelay = (prevBelow & ~inhibit & ~s_d.silenced)
			^ testToggle;
		s_d.out.insRelay  = (((s_d.alarm == AL_ALARM) & ~s_d.silenced)
			| (inhibit & cfg.inhibitFeedback)) ^ testToggle;
		s_d.out.prevLed   = prevBelow & ~inhibit;
		s_d.out.alarmLed  = (s_d.alarm == AL_ALARM);
		s_d.out.relayConnect = ~(inhibit & ~cfg.inhibitTypeExt);
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			s_q <= '{tickCnt: TICK_ZERO, delayCnt: DELAY_ZERO,
				alarm: AL_NORMAL, screen: SCR_MONITOR, silenced: 1'b0,
				acked: 1'b0, inhibPrev: 1'b0, testSec: TEST_IDLE,
				testManual: 1'b0, transient: 1'b0, out: RELAYS_RST};
		end else begin
			s_q <= s_d;
		end
	end

	assign relays         = s_q.out;
	assign screen         = s_q.screen;
	assign selfTestActive = (s_q.testSec != TEST_IDLE);
	assign transientFault = s_q.transient;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_b);

	inhibit_screen_a: assert property (
		inhibit && s_q.screen == SCR_MONITOR |=> screen == SCR_INHIBIT)
		else $error("inhibition screen not shown");
	int_retest_a: assert property (
		s_q.screen == SCR_INHIBIT && !inhibit && !cfg.inhibitTypeExt
		|=> screen == SCR_SELFTEST && selfTestActive)
		else $error("no self-test after re-enable");
	ext_return_a: assert property (
		s_q.screen == SCR_INHIBIT && !inhibit && cfg.inhibitTypeExt
		|=> screen == SCR_MONITOR && !selfTestActive)
		else $error("external style did not return to monitor");
	inhibit_feedback_a: assert property (
		inhibit && cfg.inhibitFeedback && !keys.testPress
		&& s_q.testSec == TEST_IDLE |=> relays.insRelay)
		else $error("feedback relay not energised");
	ack_silence_a: assert property (
		s_q.alarm == AL_ALARM && keys.ackPress && cfg.alarmRelaySilencing
		&& insFault && !inhibit && !keys.testPress
		&& s_q.testSec == TEST_IDLE
		|=> !relays.insRelay && !relays.prevRelay && relays.alarmLed)
		else $error("acknowledge did not release relays");
	ack_hold_a: assert property (
		s_q.alarm == AL_ALARM && keys.ackPress && !cfg.alarmRelaySilencing
		&& !s_q.silenced && insFault && !inhibit && !keys.testPress
		&& s_q.testSec == TEST_IDLE |=> relays.insRelay)
		else $error("relay released without silencing");
	alarm_nodelay_a: assert property (
		s_q.alarm == AL_NORMAL && insFault && !inhibit
		&& cfg.alarmDelaySec == DELAY_ZERO |=> relays.alarmLed)
		else $error("zero delay alarm late");
	relay_isolate_a: assert property (
		inhibit && !cfg.inhibitTypeExt |=> !relays.relayConnect)
		else $error("relay not isolated");
	relay_attach_a: assert property (
		inhibit && cfg.inhibitTypeExt |=> relays.relayConnect)
		else $error("relay not connected");
	transient_mark_a: assert property (
		s_q.alarm == AL_ALARM && !insFault && !inhibit && !s_q.acked
		&& !keys.ackPress |=> transientFault ##1 !transientFault)
		else $error("transient fault not flagged");

endmodule : insulation_alarm_relay_control

// ===== tb/inhibit_contact_model.sv
// contact and relay load model at the far side of the relay control
// assumes the bench asks for the contact state on its own clock
`timescale 1ns/100ps
module inhibit_contact_model
	import alarm_relay_pkg::*;
(
	input  logic    core_clk,
	input  logic    rst_b,
	input  logic    closeReq,
	input  relays_t relays,
	output logic    injInhibit,
	output logic    hornOn
);
	// ----------------------------------------------------------------
	// contact follows the request one clock later
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) injInhibit <= 1'b0;
		else injInhibit <= closeReq;
	end
	// ----------------------------------------------------------------
	// load sees the relay only while connected
	// ----------------------------------------------------------------
	assign hornOn = relays.insRelay & relays.relayConnect;
endmodule : inhibit_contact_model

// ===== tb/insulation_alarm_relay_control_tb.sv
// self-checking bench of the insulation alarm relay control
// assumes the package and the contact model are compiled first
`timescale 1ns/100ps
module insulation_alarm_relay_control_tb
	import alarm_relay_pkg::*;
;
	localparam int TICKS = 10;
	logic    core_clk   = 1'b0;
	logic    rst_b      = 1'b0;
	config_t cfg        = '0;
	keys_t   keys       = '0;
	logic    closeReq   = 1'b0;
	logic    prevBelow  = 1'b0;
	logic    insFault   = 1'b0;
	logic    injInhibit;
	logic    hornOn;
	relays_t relays;
	screen_t screen;
	logic    stActive;
	logic    trans;
	int      failures   = 0;
	int      n_compared = 0;
	int      cycles     = 0;

	insulation_alarm_relay_control #(.SEC_TICKS(TICKS)) i_dut (
		.core_clk(core_clk), .rst_b(rst_b), .cfg(cfg), .keys(keys),
		.injInhibit(injInhibit), .prevBelow(prevBelow),
		.insFault(insFault), .relays(relays), .screen(screen),
		.selfTestActive(stActive), .transientFault(trans));
	inhibit_contact_model i_contact (
		.core_clk(core_clk), .rst_b(rst_b), .closeReq(closeReq),
		.relays(relays), .injInhibit(injInhibit), .hornOn(hornOn));

	// ----------------------------------------------------------------
	// clock, timeout and helpers
	// ----------------------------------------------------------------
	always #25 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 3000) begin
			failures++;
			print_verdict();
		end
	end
	task print_verdict();
		$display("%0d compared, %0d failures", n_compared, failures);
		if (failures == 0 && n_compared > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : print_verdict
	task chk(logic [7:0] seen, logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			failures++;
			$display("BAD %0t seen %h exp %h", $time, seen, exp);
		end
	endtask : chk
	task step(int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask : step
	task press(keys_t k);
		keys = k;
		step(1);
		keys = '0;
	endtask : press
	function relays_t expRel(logic pb, logic al, logic sl);
		expRel = {pb & ~sl, al & ~sl, pb, al, 1'b1};
	endfunction : expRel
	task alarmRun(logic sil, logic ack);
		cfg.alarmRelaySilencing = sil;
		prevBelow = 1'b1;
		insFault = 1'b1;
		step(1);
		chk(8'(relays), 8'(expRel(1'b1, 1'b1, 1'b0)));
		keys.ackPress = ack;
		step(1);
		keys.ackPress = 1'b0;
		chk(8'(relays), 8'(expRel(1'b1, 1'b1, sil & ack)));
		prevBelow = 1'b0;
		insFault = 1'b0;
		step(1);
		chk(8'(trans), 8'(!ack));
		chk(8'(relays), 8'(expRel(1'b0, 1'b0, 1'b0)));
		$display("test alarm %0d%0d done", sil, ack);
	endtask : alarmRun
	task inhib(logic ext);
		cfg.inhibitTypeExt = ext;
		cfg.inhibitFeedback = 1'b1;
		closeReq = 1'b1;
		step(2);
		chk(8'(screen), 8'(SCR_INHIBIT));
		chk(8'(relays.relayConnect), 8'(ext));
		chk(8'(hornOn), 8'(ext));
		chk(8'(relays.insRelay), 8'h01);
		closeReq = 1'b0;
		step(2);
		chk(8'(screen), 8'(ext ? SCR_MONITOR : SCR_SELFTEST));
		chk(8'(stActive), 8'(!ext));
		chk(8'(relays.insRelay), 8'h00);
		chk(8'(relays.relayConnect), 8'h01);
		step(3 * TICKS - 3);
		chk(8'(screen), 8'(ext ? SCR_MONITOR : SCR_SELFTEST));
		for (int k = 0; k < 6 && screen !== SCR_MONITOR; k++) step(1);
		chk(8'(screen), 8'(SCR_MONITOR));
		chk(8'(stActive), 8'h00);
		$display("test inhibit %0d done", ext);
	endtask : inhib

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		void'($urandom(32'h55df_99ef));
		cfg.testWithRelays = 1'b1;
		cfg.inhibitEnable = 1'b1;
		step(6);
		chk(8'(relays), 8'(RELAYS_RST));
		rst_b = 1'b1;
		for (int i = 0; i < 20; i++) begin
			prevBelow = 1'($urandom);
			keys.ackPress = 1'($urandom);
			step(1);
			chk(8'(relays), 8'(expRel(prevBelow, 1'b0, 1'b0)));
		end
		keys.ackPress = 1'b0;
		prevBelow = 1'b0;
		step(1);
		$display("test random done");
		alarmRun(1'b1, 1'b1);
		alarmRun(1'b0, 1'b1);
		alarmRun(1'b1, 1'b0);
		cfg.alarmDelaySec = 13'h0002;
		insFault = 1'b1;
		step(TICKS - 2);
		chk(8'(relays.alarmLed), 8'h00);
		for (int k = 0; k < 2 * TICKS && relays.alarmLed !== 1'b1; k++) step(1);
		chk(8'(relays.alarmLed), 8'h01);
		insFault = 1'b0;
		step(2);
		$display("test delay done");
		inhib(1'b0);
		inhib(1'b1);
		keys.testPress = 1'b1;
		step(1);
		keys.testPress = 1'b0;
		chk(8'(screen), 8'(SCR_SELFTEST));
		step(TICKS);
		chk(8'({relays.prevRelay, relays.insRelay}), 8'h03);
		step(3 * TICKS);
		chk(8'({relays.prevRelay, relays.insRelay}), 8'h00);
		$display("test manual done");
		closeReq = 1'b1;
		step(2);
		keys.menuPress = 1'b1;
		step(1);
		keys.menuPress = 1'b0;
		chk(8'(screen), 8'(SCR_MENU));
		press(5'h01);
		chk(8'(screen), 8'(SCR_INHIBIT));
		press(5'h04);
		chk(8'(screen), 8'(SCR_SETTINGS));
		press(5'h01);
		press(5'h02);
		chk(8'(screen), 8'(SCR_SELFTEST));
		chk(8'(stActive), 8'h01);
		chk(8'({relays.prevRelay, relays.insRelay}), 8'h02);
		$display("test menu done");
		print_verdict();
	end
endmodule : insulation_alarm_relay_control_tb
